// ---- design/lpc_bank.v ----
// Register bank for indicator PWM, converter frequency mode and current reports.
// Contract
// - PWM duty is one to four sixteenths.
// - Duty applies only in indicator mode.
// - Force bit clear allows pulse-skipping everywhere.
// - Force set, high current, assist or flash mode: fixed frequency.
// - Indicator mode always uses pulse-skipping.
// - Read-only minimum current report, resets zero.
// - Minimum includes undervoltage, excludes mask.
// - Minimum written on undervoltage reduction; a cycle start without one clears it to zero.
// - Read-only applied current report, resets zero.
// - Applied report follows reductions and ramps.
// - Self-clearing status bits clear after read.
`timescale 1ns/1ns
`include "lpc_regs.vh"
module lpc_bank #(
  parameter SLOT_CYCLES = `LPC_SLOT_CYCLES
) (
  input wire clock_i,             // System clock, 25 MHz.
  input wire reset_n_i,           // Synchronous reset, active low.
  input wire [3:0] addr_i,        // Register address.
  input wire wr_i,                // Write strobe.
  input wire rd_i,                // Read strobe.
  input wire [7:0] wdata_i,       // Write data.
  input wire [1:0] mode_i,        // Light mode selector.
  input wire [7:0] set_current_i, // Programmed sink current.
  input wire [7:0] applied_i,     // Current now applied by the sink.
  input wire uv_reduce_i,         // Undervoltage reduction active.
  input wire [7:0] uv_current_i,  // Current after undervoltage reduction.
  input wire cycle_active_i,      // Operation cycle in progress.
  input wire uv_event_i,          // Undervoltage fault event pulse.
  output reg [7:0] rdata_o,       // Read data.
  output reg pwm_o,               // Indicator PWM enable.
  output reg pulse_skip_o,        // Converter may pulse-skip.
  output reg fixed_high_o,        // Fixed-frequency at high rate.
  output reg uv_flag_o            // Undervoltage flag, read-self-clear.
);
  // Stored registers and their next values.
  reg [7:0] cfg_r;
  reg [7:0] cfg_nxt;
  reg [7:0] act_r;
  reg [7:0] act_nxt;

  // Next values of the registered outputs.
  reg [7:0] rdata_nxt;
  reg pwm_nxt;
  reg skip_nxt;
  reg high_nxt;
  reg flag_nxt;

  // Results of the two sub-blocks.
  wire pwm_raw;
  wire [7:0] min_cur;

  // Decoded controls of the bank.
  wire indicator;
  wire force_fix;
  wire fix_now;
  wire cfg_wr;
  wire flag_clr;

  // Reset values of the registered outputs.
  localparam [7:0] RDATA_RESET = 8'h00;
  localparam PWM_RESET = 1'b0;
  localparam SKIP_RESET = 1'b1;
  localparam HIGH_RESET = 1'b0;
  localparam FLAG_RESET = 1'b0;

  // True when the address selects the given register.
  function addr_hit;
    input [3:0] addr;
    input [3:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // True in the indicator or low-current light mode.
  function mode_is_indicator;
    input [1:0] mode;
    begin
      mode_is_indicator = (mode == `LPC_MODE_INDICATOR);
    end
  endfunction

  // True in the assist or flash light mode.
  function mode_is_high;
    input [1:0] mode;
    begin
      mode_is_high = (mode == `LPC_MODE_ASSIST) || (mode == `LPC_MODE_FLASH);
    end
  endfunction

  // True in flash mode, which runs the fast fixed rate.
  function mode_is_flash;
    input [1:0] mode;
    begin
      mode_is_flash = (mode == `LPC_MODE_FLASH);
    end
  endfunction

  // True when pulse-skipping must give way to a fixed frequency.
  // Indicator mode keeps pulse-skipping whatever the force bit holds.
  function fixed_wanted;
    input force_bit;
    input [1:0] mode;
    input [7:0] current;
    begin
      fixed_wanted = 1'b0;
      if (force_bit) begin
        if (!mode_is_indicator(mode)) begin
          if (mode_is_high(mode)) begin
            if (current >= `LPC_FIXFREQ_THRESH) begin
              fixed_wanted = 1'b1;
            end
          end
        end
      end
    end
  endfunction

  // Stored image of a configuration write; undefined bits stay zero.
  function [7:0] cfg_image;
    input [7:0] data;
    begin
      cfg_image = {5'h00, data[`LPC_FREQ_FORCE_BIT:`LPC_DUTY_LSB]};
    end
  endfunction

  // Read data of one register; unmapped addresses read as zero.
  // The three addresses never overlap, so the order of the tests is free.
  function [7:0] read_mux;
    input [3:0] addr;
    input [7:0] cfg;
    input [7:0] min_val;
    input [7:0] act;
    begin
      read_mux = 8'h00;
      if (addr_hit(addr, `LPC_ADDR_PWM_CFG)) begin
        read_mux = cfg;
      end
      if (addr_hit(addr, `LPC_ADDR_MIN_CUR)) begin
        read_mux = min_val;
      end
      if (addr_hit(addr, `LPC_ADDR_ACT_CUR)) begin
        read_mux = act;
      end
    end
  endfunction

  // Control decode shared by the processes below.
  assign indicator = mode_is_indicator(mode_i);
  assign force_fix = cfg_r[`LPC_FREQ_FORCE_BIT];
  assign fix_now = fixed_wanted(force_fix, mode_i, set_current_i);
  assign cfg_wr = wr_i && addr_hit(addr_i, `LPC_ADDR_PWM_CFG);
  assign flag_clr = rd_i && uv_flag_o;

  // PWM runs only in indicator mode.
  lpc_pwm_gen #(
    .SLOT_CYCLES(SLOT_CYCLES)
  ) u_pwm (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .enable_i(indicator),
    .duty_i(cfg_r[`LPC_DUTY_MSB:`LPC_DUTY_LSB]),
    .pwm_o(pwm_raw)
  );

  lpc_min_track u_min (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .active_i(cycle_active_i),
    .uv_reduce_i(uv_reduce_i),
    .uv_current_i(uv_current_i),
    .min_o(min_cur)
  );

  // The next-value logic follows, one process for each register.
  // Configuration register, written only at its own address.
  always @* begin
    cfg_nxt = cfg_r;
    if (cfg_wr) begin
      cfg_nxt = cfg_image(wdata_i);
    end
  end

  always @* begin
    act_nxt = applied_i;
  end

  // The PWM passes one more flip-flop so that the pin comes from a register.
  always @* begin
    pwm_nxt = pwm_raw;
  end

  always @* begin
    skip_nxt = 1'b1;
    if (fix_now) begin
      skip_nxt = 1'b0;
    end
  end

  // Outside the fixed mode the rate bit rests low.
  // flash fast, assist slow.
  always @* begin
    high_nxt = 1'b0;
    if (fix_now) begin
      high_nxt = mode_is_flash(mode_i);
    end
  end

  // The flag is the block's copy of the undervoltage fault bit.
  // set wins over read clear.
  always @* begin
    flag_nxt = uv_flag_o;
    if (uv_event_i) begin
      flag_nxt = 1'b1;
    end else if (flag_clr) begin
      flag_nxt = 1'b0;
    end
  end

  // Read data holds until the next read strobe.
  always @* begin
    rdata_nxt = rdata_o;
    if (rd_i) begin
      rdata_nxt = read_mux(addr_i, cfg_r, min_cur, act_r);
    end
  end

  // The registers follow; every output is taken straight from one of them.
  // Configuration register.
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      cfg_r <= `LPC_PWM_CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // Applied current copy.
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      act_r <= `LPC_ACT_CUR_RESET;
    end else begin
      act_r <= act_nxt;
    end
  end

  // Read data.
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      rdata_o <= RDATA_RESET;
    end else begin
      rdata_o <= rdata_nxt;
    end
  end

  // Indicator PWM output.
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      pwm_o <= PWM_RESET;
    end else begin
      pwm_o <= pwm_nxt;
    end
  end

  // Pulse-skip permission.
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      pulse_skip_o <= SKIP_RESET;
    end else begin
      pulse_skip_o <= skip_nxt;
    end
  end

  // Fixed-frequency rate select.
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      fixed_high_o <= HIGH_RESET;
    end else begin
      fixed_high_o <= high_nxt;
    end
  end

  // Undervoltage flag.
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      uv_flag_o <= FLAG_RESET;
    end else begin
      uv_flag_o <= flag_nxt;
    end
  end
endmodule

// ---- design/lpc_regs.vh ----
// Register offsets, field positions, reset values and timing counts of the PWM and current report bank.
`ifndef LPC_REGS_VH
`define LPC_REGS_VH
`define LPC_ADDR_PWM_CFG 4'h9
`define LPC_ADDR_MIN_CUR 4'he
`define LPC_ADDR_ACT_CUR 4'hf
`define LPC_PWM_CFG_RESET 8'h00
`define LPC_MIN_CUR_RESET 8'h00
`define LPC_ACT_CUR_RESET 8'h00
`define LPC_DUTY_LSB 0
`define LPC_DUTY_MSB 1
`define LPC_FREQ_FORCE_BIT 2
`define LPC_MODE_OFF 2'b00
`define LPC_MODE_INDICATOR 2'b01
`define LPC_MODE_ASSIST 2'b10
`define LPC_MODE_FLASH 2'b11
`define LPC_FIXFREQ_THRESH 8'h40
`define LPC_CLK_HZ 25000000
`define LPC_PWM_HZ 31250
`define LPC_PWM_SLOTS 16
// Cycles per PWM slot: 25 MHz / (31.25 kHz * 16) = 50.
`define LPC_SLOT_CYCLES (`LPC_CLK_HZ / (`LPC_PWM_HZ * `LPC_PWM_SLOTS))
`endif

// ---- design/lpc_pwm_gen.v ----
// Indicator PWM generator with sixteen slots per period.
`timescale 1ns/1ns
`include "lpc_regs.vh"
module lpc_pwm_gen #(
  parameter SLOT_CYCLES = `LPC_SLOT_CYCLES
) (
  input wire clock_i,      // System clock.
  input wire reset_n_i,    // Synchronous reset, active low.
  input wire enable_i,     // Run the PWM.
  input wire [1:0] duty_i, // Duty code.
  output reg pwm_o         // PWM output.
);
  reg [7:0] div_r;
  reg [3:0] slot_r;
  wire slot_end = (div_r == SLOT_CYCLES[7:0] - 8'h01);

  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      div_r <= 8'h00;
      slot_r <= 4'h0;
      pwm_o <= 1'b0;
    end else if (!enable_i) begin
      div_r <= 8'h00;
      slot_r <= 4'h0;
      pwm_o <= 1'b0;
    end else begin
      div_r <= slot_end ? 8'h00 : div_r + 8'h01;
      if (slot_end)
        slot_r <= slot_r + 4'h1;
      // high for code plus one slots.
      // duty of one to four sixteenths.
      pwm_o <= (slot_r <= {2'b00, duty_i});
    end
  end
endmodule

// ---- design/lpc_min_track.v ----
// Tracker of the lowest undervoltage-reduced sink current of a cycle.
`timescale 1ns/1ns
`include "lpc_regs.vh"
module lpc_min_track (
  input wire clock_i,            // System clock.
  input wire reset_n_i,          // Synchronous reset, active low.
  input wire active_i,           // Operation cycle in progress.
  input wire uv_reduce_i,        // Undervoltage reduction is acting.
  input wire [7:0] uv_current_i, // Current after undervoltage reduction only.
  output reg [7:0] min_o         // Reported minimum.
);
  reg active_d_r;
  reg seen_r;

  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      active_d_r <= 1'b0;
      seen_r <= 1'b0;
      min_o <= `LPC_MIN_CUR_RESET;
    end else begin
      active_d_r <= active_i;
      if (active_i && !active_d_r) begin
        // A new cycle restarts the minimum but keeps its own first sample.
        seen_r <= uv_reduce_i;
        min_o <= uv_reduce_i ? uv_current_i : `LPC_MIN_CUR_RESET;
      end else if (active_i && uv_reduce_i) begin
        // store only on a real reduction.
        // track undervoltage current, not mask current.
        seen_r <= 1'b1;
        if (!seen_r || uv_current_i < min_o)
          min_o <= uv_current_i;
      end
    end
  end
endmodule

// ---- testbench/lpc_chk_assertions.sv ----
// Assertion checker for the PWM and current report bank.
`timescale 1ns/1ns
module lpc_chk (
  input wire clock_i, reset_n_i, rd_i, uv_event_i, pwm_o, pulse_skip_o, fixed_high_o, uv_flag_o,
  input wire [3:0] addr_i,
  input wire [1:0] mode_i,
  input wire [7:0] set_current_i, applied_i, rdata_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  AST_IND: assert property (mode_i == 2'h1 |=> pulse_skip_o) else $error("skip");
  AST_FIX: assert property (!pulse_skip_o |-> $past(mode_i[1] && set_current_i >= 8'h40)) else $error("fix");
  AST_RATE: assert property (!pulse_skip_o |-> fixed_high_o == $past(mode_i[0])) else $error("rate");
  AST_PWM: assert property ((mode_i != 2'h1) [*3] |-> !pwm_o) else $error("pwm");
  AST_UV: assert property (uv_event_i |=> uv_flag_o) else $error("set");
  AST_CLR: assert property (rd_i && !uv_event_i |=> !uv_flag_o) else $error("clr");
  AST_ACT: assert property (rd_i && addr_i == 4'hf && $stable(applied_i) |=> rdata_o == $past(applied_i)) else $error("act");
  AST_GAP: assert property (rd_i && addr_i < 4'h9 |=> rdata_o == 8'h00) else $error("gap");
  cover property (!pulse_skip_o && fixed_high_o);
  cover property ($rose(pwm_o));
  cover property (rd_i && addr_i == 4'he);
endmodule

// ---- testbench/lpc_host.sv ----
// Host model that issues single-byte register accesses.
`timescale 1ns/1ns
module lpc_host (
  input wire clock_i, // Clock.
  output reg [3:0] addr_o, // Address.
  output reg wr_o, // Write strobe.
  output reg rd_o, // Read strobe.
  output reg [7:0] wdata_o // Write data.
);
  initial {addr_o, wr_o, rd_o, wdata_o} = 14'h0000;
  // The strobe stands for exactly one rising edge; read data is valid after it.
  task acc(input w, input [3:0] a, input [7:0] d);
    @(negedge clock_i);
    {addr_o, wr_o, rd_o, wdata_o} = {a, w, !w, d};
    @(negedge clock_i);
    {wr_o, rd_o} = 2'h0;
  endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the PWM and current report bank.
`timescale 1ns/1ns
module tb;
  reg clock_i = 0, reset_n_i = 0, uv_reduce_i = 0, cycle_active_i = 0, uv_event_i = 0;
  reg [1:0] mode_i = 0;
  reg [7:0] set_current_i = 0, applied_i = 0, uv_current_i = 0;
  wire [3:0] addr_i;
  wire wr_i, rd_i, pwm_o, pulse_skip_o, fixed_high_o, uv_flag_o;
  wire [7:0] wdata_i, rdata_o;
  integer n_fail = 0, checks_done = 0, i, r;
  // Rows: force bit, mode, set current, expected skip and high-rate bits.
  localparam [119:0] ROWS = {20'h1_3401, 20'h1_2ff0, 20'h1_33f2, 20'h1_1ff2, 20'h0_3ff2, 20'h1_0ff2};
  initial forever #20 clock_i = !clock_i;
  lpc_host host (.clock_i(clock_i), .addr_o(addr_i), .wr_o(wr_i), .rd_o(rd_i), .wdata_o(wdata_i));
  lpc_bank #(.SLOT_CYCLES(2)) dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wr_i(wr_i),
    .rd_i(rd_i), .wdata_i(wdata_i), .mode_i(mode_i), .set_current_i(set_current_i), .applied_i(applied_i),
    .uv_reduce_i(uv_reduce_i), .uv_current_i(uv_current_i), .cycle_active_i(cycle_active_i),
    .uv_event_i(uv_event_i), .rdata_o(rdata_o), .pwm_o(pwm_o), .pulse_skip_o(pulse_skip_o),
    .fixed_high_o(fixed_high_o), .uv_flag_o(uv_flag_o));
  task cmp(input [7:0] g, input [7:0] e);
    checks_done = checks_done + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rd(input [3:0] a, input [7:0] e);
    host.acc(1'b0, a, 8'h00);
    cmp(rdata_o, e);
  endtask
  task give_verdict;
    $display("%0d checks, %0d fails", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100000 n_fail = n_fail + 1;
    give_verdict;
  end
  initial begin
    repeat (16) @(negedge clock_i);
    reset_n_i = 1;
    cmp({4'h0, pwm_o, pulse_skip_o, fixed_high_o, uv_flag_o}, 8'h04);
    host.acc(1'b1, 4'he, 8'h55);
    rd(4'he, 8'h00);
    rd(4'hf, 8'h00);
    rd(4'h3, 8'h00);
    rd(4'h9, 8'h00);
    $display("reset test done");
    for (i = 0; i < 6; i = i + 1) begin
      r = ROWS[i * 20 +: 20];
      host.acc(1'b1, 4'h9, {5'h00, r[16], 2'h3});
      mode_i = r[13:12];
      set_current_i = r[11:4];
      repeat (2) @(negedge clock_i);
      cmp({6'h00, pulse_skip_o, fixed_high_o}, {6'h00, r[1:0]});
    end
    $display("mode test done");
    mode_i = 2'h1;
    for (i = 0; i < 4; i = i + 1) begin
      host.acc(1'b1, 4'h9, i[7:0]);
      repeat (40) @(negedge clock_i);
      r = 0;
      repeat (64) @(negedge clock_i) r = r + pwm_o;
      cmp(r[7:0], 8'h04 * i[7:0] + 8'h04);
    end
    mode_i = 2'h2;
    repeat (3) @(negedge clock_i);
    r = 0;
    repeat (64) @(negedge clock_i) r = r + pwm_o;
    cmp(r[7:0], 8'h00);
    $display("pwm test done");
    {cycle_active_i, uv_reduce_i, uv_event_i, uv_current_i} = {3'h7, 8'h50};
    @(negedge clock_i);
    {uv_event_i, uv_current_i} = {1'b0, 8'h60};
    repeat (3) @(negedge clock_i);
    cycle_active_i = 0;
    cmp({7'h00, uv_flag_o}, 8'h01);
    rd(4'he, 8'h50);
    cmp({7'h00, uv_flag_o}, 8'h00);
    applied_i = 8'h3c;
    rd(4'hf, 8'h3c);
    rd(4'hf, 8'h3c);
    $display("report test done");
    uv_reduce_i = 0;
    cycle_active_i = 1;
    @(negedge clock_i);
    cycle_active_i = 0;
    rd(4'he, 8'h00);
    {cycle_active_i, uv_reduce_i, uv_current_i, mode_i, set_current_i} = {2'h3, 8'h20, 2'h3, 8'hff};
    host.acc(1'b1, 4'h9, 8'h04);
    @(negedge clock_i);
    cmp({6'h00, pulse_skip_o, fixed_high_o}, 8'h01);
    rd(4'he, 8'h20);
    {reset_n_i, cycle_active_i, uv_reduce_i} = 3'h0;
    repeat (2) @(negedge clock_i);
    reset_n_i = 1;
    @(negedge clock_i);
    cmp({4'h0, pwm_o, pulse_skip_o, fixed_high_o, uv_flag_o}, 8'h04);
    rd(4'h9, 8'h00);
    rd(4'he, 8'h00);
    $display("mid-run reset test done");
    give_verdict;
  end
endmodule
bind lpc_bank lpc_chk chk (.clock_i(clock_i), .reset_n_i(reset_n_i), .rd_i(rd_i), .uv_event_i(uv_event_i),
  .pwm_o(pwm_o), .pulse_skip_o(pulse_skip_o), .fixed_high_o(fixed_high_o), .uv_flag_o(uv_flag_o),
  .addr_i(addr_i), .mode_i(mode_i), .set_current_i(set_current_i), .applied_i(applied_i), .rdata_o(rdata_o));
